// file: hdl/adc_pkg.sv
//==============================================================
// Contract
// - One conversion per converter clock cycle
// - Phase high: balance clock high, sample low
// - Phase low: rising edge starts sample
// - Phase input inverts the incoming clock
// - Sample end captures comparators, first row
// - Balance end copies first row to second
// - Decode to nine bits, load next sample end
// - Output load pipelines one result per cycle
// - Result valid after next same-polarity edge
// - Disable-high input floats data outputs
// - Enable-low input floats all nine outputs
package adc_pkg;
  //==============================================================
  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 9;
  localparam int unsigned COMP_N = 256;
  localparam int unsigned BUF_DEPTH = 2;
  //==============================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SAMPLE_MAX_NS = 500;
  // Longest time, rounds down
  localparam int unsigned SAMPLE_MAX_CYC = SAMPLE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned OT_CNT_W = 7;
  //==============================================================
  // Reset values and codes
  localparam logic [CODE_W-1:0] CODE_RST = 9'h000;
  localparam logic [CODE_W-1:0] CODE_OVER = 9'h1ff;
  localparam logic [CODE_W-1:0] CODE_FULL_CNT = 9'h100;
  localparam logic [OT_CNT_W-1:0] OT_CNT_RST = 7'h00;
  localparam logic [OT_CNT_W-1:0] OT_CNT_ONE = 7'h01;
  localparam logic [OT_CNT_W-1:0] OT_CNT_MAX = OT_CNT_W'(SAMPLE_MAX_CYC);

  // Thermometer to straight binary; all ones means overflow
  function automatic logic [CODE_W-1:0] therm_decode(input logic [COMP_N-1:0] t);
    logic [CODE_W-1:0] cnt;
    cnt = CODE_RST;
    for (int i = 0; i < COMP_N; i++) begin
      cnt = cnt + CODE_W'(t[i]);
    end
    return (cnt == CODE_FULL_CNT) ? CODE_OVER : cnt;
  endfunction
endpackage

// file: hdl/stream_if.sv
`timescale 1ns/10ps
//==============================================================
// Valid/ready word carrier
interface stream_if #(parameter int unsigned W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hdl/pipe_buffer.sv
`timescale 1ns/10ps
//==============================================================
// Two-entry buffer, flip-flop storage
module pipe_buffer #(
  parameter int unsigned W = adc_pkg::CODE_W,
  parameter int unsigned DEPTH = adc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill and drain sides
  stream_if.snk in_s,
  stream_if.src out_s
);
  import adc_pkg::*;
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_ZERO = '0;
  localparam logic [PW:0] CNT_ZERO = '0;

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [PW:0] cnt_q;
  wire push = in_s.valid & in_s.ready;
  wire pop = out_s.valid & out_s.ready;
  wire [PW-1:0] wr_nx = (wr_q == PTR_LAST) ? PTR_ZERO : wr_q + PW'(1);
  wire [PW-1:0] rd_nx = (rd_q == PTR_LAST) ? PTR_ZERO : rd_q + PW'(1);

  assign in_s.ready = (cnt_q != CNT_FULL);
  assign out_s.valid = (cnt_q != CNT_ZERO);
  assign out_s.data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= PTR_ZERO;
      rd_q <= PTR_ZERO;
      cnt_q <= CNT_ZERO;
    end else begin
      if (push) wr_q <= wr_nx;
      if (pop) rd_q <= rd_nx;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // pipe_buffer

// file: hdl/flash_adc_sample_pipeline.sv
`timescale 1ns/10ps
module flash_adc_sample_pipeline (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Converter clock and phase control
  input wire logic conv_clk,
  input wire logic phase_ctl,
  // Comparator thermometer, bit i high when input above tap i+1
  input wire logic [adc_pkg::COMP_N-1:0] comp_in,
  // Output enables
  input wire logic data_out_disable_hi,
  input wire logic all_out_enable_lo,
  // Three-state data pins
  output logic [adc_pkg::DATA_W-1:0] result_bits,
  output logic [adc_pkg::DATA_W-1:0] result_oe,
  output logic over_range_flag,
  output logic over_range_oe,
  // Result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [adc_pkg::CODE_W-1:0] res_data,
  // Status
  output logic pipe_stall,
  output logic sample_overtime
);
  import adc_pkg::*;

  //==============================================================
  // Phase decode
  logic sample_q;
  logic v1_q, v2_q;
  logic [COMP_N-1:0] row1_q, row2_q;
  logic [CODE_W-1:0] out_q;
  logic [OT_CNT_W-1:0] ot_cnt_q, ot_cnt_d;
  logic ot_q;

  stream_if #(.W(CODE_W)) push_s ();
  stream_if #(.W(CODE_W)) pop_s ();

  // Phase input complements the clock on entry
  wire sample_phase = conv_clk ^ phase_ctl;
  wire sample_end = sample_q & ~sample_phase;
  wire bal_end = ~sample_q & sample_phase;
  wire [CODE_W-1:0] dec_code = therm_decode(row2_q);
  // Full buffer freezes the whole pipe rather than lose a word
  wire hold = push_s.valid & ~push_s.ready;
  wire advance = sample_end & ~hold;

  assign push_s.valid = sample_end & v2_q;
  assign push_s.data = dec_code;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_q <= 1'b0;
    end else begin
      sample_q <= sample_phase;
    end
  end

  //==============================================================
  // Latch rows and output register
  always_ff @(posedge clk) begin
    if (advance) begin
      row1_q <= comp_in;
    end
    if (bal_end) begin
      row2_q <= row1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      out_q <= CODE_RST;
    end else begin
      if (advance) v1_q <= 1'b1;
      if (bal_end) v2_q <= v1_q;
      if (advance && v2_q) out_q <= dec_code;
    end
  end

  //==============================================================
  // Sample-phase length watch
  // Only flags droop risk; the clock source must avoid it
  assign ot_cnt_d = !sample_phase ? OT_CNT_RST :
                    (ot_cnt_q == OT_CNT_MAX) ? ot_cnt_q : ot_cnt_q + OT_CNT_ONE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ot_cnt_q <= OT_CNT_RST;
      ot_q <= 1'b0;
    end else begin
      ot_cnt_q <= ot_cnt_d;
      ot_q <= (ot_cnt_d == OT_CNT_MAX);
    end
  end

  //==============================================================
  // Buffer and pins
  pipe_buffer #(.W(CODE_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_s(push_s),
    .out_s(pop_s)
  );

  assign res_valid = pop_s.valid;
  assign res_data = pop_s.data;
  assign pop_s.ready = res_ready;
  assign pipe_stall = hold;
  assign sample_overtime = ot_q;

  assign result_bits = out_q[DATA_W-1:0];
  assign over_range_flag = out_q[CODE_W-1];
  assign result_oe = {DATA_W{all_out_enable_lo & ~data_out_disable_hi}};
  assign over_range_oe = all_out_enable_lo;

  //==============================================================
  // Checks
  a_row1_capture: assert property (@(posedge clk) disable iff (sys_rst)
    advance |=> row1_q == $past(comp_in))
    else $error("first row missed capture at sample end");

  a_row2_copy: assert property (@(posedge clk) disable iff (sys_rst)
    bal_end |=> row2_q == $past(row1_q))
    else $error("second row missed copy at balance end");

  a_out_load: assert property (@(posedge clk) disable iff (sys_rst)
    (advance && v2_q) |=> out_q == $past(dec_code) && res_valid)
    else $error("output register missed decoded code");

  a_out_only_at_end: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(out_q) |-> $past(sample_end))
    else $error("output changed away from sample end");

  a_high_phase_sample: assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(conv_clk) && !phase_ctl && $stable(phase_ctl)) |=> !sample_end && sample_q)
    else $error("rising clock did not start sample");

  a_low_phase_sample: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(conv_clk) && phase_ctl && $stable(phase_ctl)) |=> sample_q)
    else $error("low clock with phase high not sampling");

  a_all_float: assert property (@(posedge clk) disable iff (sys_rst)
    !all_out_enable_lo |-> result_oe == '0 && !over_range_oe)
    else $error("outputs driven while enable low");

  a_data_float: assert property (@(posedge clk) disable iff (sys_rst)
    (data_out_disable_hi && all_out_enable_lo) |-> result_oe == '0 && over_range_oe)
    else $error("data disable wrong");

  a_over_full: assert property (@(posedge clk) disable iff (sys_rst)
    over_range_flag |-> result_bits == {DATA_W{1'b1}})
    else $error("overflow without full-scale data");

  a_overtime_flag: assert property (@(posedge clk) disable iff (sys_rst)
    sample_phase [*8] |-> ##[0:60] (sample_overtime || !sample_phase))
    else $error("long sample not flagged");

  a_stall_row1: assert property (@(posedge clk) disable iff (sys_rst)
    hold |=> $stable(row1_q))
    else $error("first row moved during stall");

  a_stall_out: assert property (@(posedge clk) disable iff (sys_rst)
    hold |=> $stable(out_q))
    else $error("output register moved during stall");

  a_stall_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (sample_end && v2_q && !push_s.ready) |-> pipe_stall)
    else $error("full buffer not reported");

  a_row1_only_end: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(row1_q) |-> $past(advance))
    else $error("first row changed away from sample end");

  a_row2_only_bal: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(row2_q) |-> $past(bal_end))
    else $error("second row changed away from balance end");

  a_high_clk_bal: assert property (@(posedge clk) disable iff (sys_rst)
    (phase_ctl && $stable(phase_ctl) && conv_clk) |=> !sample_q)
    else $error("high clock with phase high not balancing");

  a_low_clk_bal: assert property (@(posedge clk) disable iff (sys_rst)
    (!phase_ctl && $stable(phase_ctl) && !conv_clk) |=> !sample_q)
    else $error("low clock with phase low not balancing");

  a_prime_order: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(v2_q) |-> $past(v1_q))
    else $error("second stage primed before first");

  a_overtime_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !sample_phase |=> !sample_overtime)
    else $error("overtime flag left set in balance");

  a_overtime_in_sample: assert property (@(posedge clk) disable iff (sys_rst)
    sample_overtime |-> sample_q)
    else $error("overtime flag outside sample");

  a_data_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (!data_out_disable_hi && all_out_enable_lo) |-> result_oe == {DATA_W{1'b1}} && over_range_oe)
    else $error("outputs not driven while enabled");

  a_head_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (res_valid && !res_ready) |=> res_valid && $stable(res_data))
    else $error("result word lost before acceptance");

  a_decode_over: assert property (@(posedge clk) disable iff (sys_rst)
    (row2_q == {COMP_N{1'b1}}) |-> dec_code == CODE_OVER)
    else $error("all comparators high not decoded as overflow");

  a_decode_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (row2_q == {COMP_N{1'b0}}) |-> dec_code == CODE_RST)
    else $error("no comparator high not decoded as zero");

  c_load: cover property (@(posedge clk) disable iff (sys_rst) advance && v2_q);
  c_data_off: cover property (@(posedge clk) disable iff (sys_rst) data_out_disable_hi && all_out_enable_lo);
  c_overflow: cover property (@(posedge clk) disable iff (sys_rst) $rose(over_range_flag));
  c_stall: cover property (@(posedge clk) disable iff (sys_rst) hold);
  c_overtime: cover property (@(posedge clk) disable iff (sys_rst) $rose(sample_overtime));
endmodule // flash_adc_sample_pipeline

// file: verif/conv_clk_source.sv
`timescale 1ns/10ps
//==========
// Converter clock source, parks in balance when idle
module conv_clk_source (
  // Clock
  input wire logic clk,
  // Control
  input wire logic run,
  input wire logic phase_ctl,
  input wire logic [7:0] half,
  // Converter clock
  output logic conv_clk
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!run) begin
      conv_clk <= phase_ctl;
      cnt_q <= 8'h00;
    end else if (cnt_q + 8'h01 >= half) begin
      conv_clk <= ~conv_clk;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // conv_clk_source

// file: verif/tb.sv
`timescale 1ns/10ps
//==========
// Bench top
module tb;
  import adc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, phase_ctl = 1'b0, run = 1'b0, res_ready = 1'b1;
  logic data_out_disable_hi = 1'b0, all_out_enable_lo = 1'b1, conv_clk, sp_q, stall_seen;
  logic res_valid, pipe_stall, sample_overtime, over_range_flag, over_range_oe;
  logic [7:0] half = 8'h05, result_bits, result_oe;
  logic [COMP_N-1:0] comp_in = '0;
  logic [CODE_W-1:0] res_data;
  logic [CODE_W-1:0] got[$];
  int n_mismatch = 0, samples_checked = 0;
  flash_adc_sample_pipeline flash_adc_sample_pipeline_i (.clk, .sys_rst, .conv_clk, .phase_ctl,
    .comp_in, .data_out_disable_hi, .all_out_enable_lo, .result_bits, .result_oe,
    .over_range_flag, .over_range_oe, .res_valid, .res_ready, .res_data, .pipe_stall,
    .sample_overtime);
  conv_clk_source conv_clk_source_i (.clk, .run, .phase_ctl, .half, .conv_clk);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    sp_q <= conv_clk ^ phase_ctl;
    if (res_valid === 1'b1 && res_ready === 1'b1) got.push_back(res_data);
    if (pipe_stall === 1'b1) stall_seen <= 1'b1;
  end
  //==========
  // Helpers
  task automatic chk(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] e);
    samples_checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  function automatic logic [COMP_N-1:0] therm(input int k);
    return ~{COMP_N{1'b0}} >> (COMP_N - k);
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Same edge the pipeline uses, so comp_in moves just after capture
  task automatic sample_end();
    @(posedge clk iff (sp_q === 1'b1 && (conv_clk ^ phase_ctl) === 1'b0));
    #1;
  endtask
  task automatic rst(input logic ph);
    sys_rst = 1'b1;
    run = 1'b0;
    half = 8'h05;
    phase_ctl = ph;
    res_ready = 1'b1;
    stall_seen = 1'b0;
    idle(3);
    sys_rst = 1'b0;
    got.delete();
  endtask
  //==========
  // Scenarios
  task automatic t_codes();
    int v[6] = '{0, 1, 127, 128, 255, 256};
    rst(1'b0);
    run = 1'b1;
    foreach (v[i]) begin
      comp_in = therm(v[i]);
      sample_end();
    end
    repeat (2) sample_end();
    run = 1'b0;
    idle(3);
    for (int i = 0; i < 5; i++) chk(got[i], CODE_W'(v[i]));
    chk(got[5], 9'h1ff);
    chk({over_range_flag, result_bits}, 9'h1ff);
  endtask
  task automatic t_pulse(input logic ph);
    rst(ph);
    res_ready = 1'b0;
    comp_in = therm(200);
    run = 1'b1;
    sample_end();
    comp_in = therm(3);
    run = 1'b0;
    idle(60);
    chk(res_valid, 9'h000);
    chk(sample_overtime, 9'h000);
    run = 1'b1;
    sample_end();
    run = 1'b0;
    idle(3);
    chk(res_valid, 9'h001);
    chk(res_data, 9'h0c8);
  endtask
  task automatic t_stall();
    rst(1'b0);
    res_ready = 1'b0;
    half = 8'h03;
    run = 1'b1;
    for (int i = 10; i < 18; i++) begin
      comp_in = therm(i);
      sample_end();
    end
    chk(stall_seen, 9'h001);
    res_ready = 1'b1;
    repeat (4) sample_end();
    run = 1'b0;
    idle(3);
    chk(got[0], 9'h00a);
    chk(got[1], 9'h00b);
    chk(got.size() >= 5, 9'h001);
    for (int i = 2; i < got.size(); i++) chk(got[i] >= got[i-1], 9'h001);
  endtask
  task automatic t_enables();
    for (int i = 0; i < 4; i++) begin
      {data_out_disable_hi, all_out_enable_lo} = i[1:0];
      idle(1);
      chk(result_oe, (i == 1) ? 9'h0ff : 9'h000);
      chk(over_range_oe, all_out_enable_lo);
    end
    data_out_disable_hi = 1'b0;
    all_out_enable_lo = 1'b1;
  endtask
  // Deliberately overlong sample; the flag is status only
  task automatic t_overtime();
    rst(1'b0);
    half = 8'h3c;
    run = 1'b1;
    @(posedge clk iff conv_clk === 1'b1);
    idle(55);
    chk(sample_overtime, 9'h001);
    sample_end();
    idle(2);
    chk(sample_overtime, 9'h000);
    run = 1'b0;
  endtask
  //==========
  // Sequence and verdict
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    t_codes();
    t_pulse(1'b0);
    t_pulse(1'b1);
    t_stall();
    t_enables();
    t_overtime();
    end_of_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule // tb
